// ==== verilog/adc_cfg_pkg.sv ====
package adc_cfg_pkg;

  // ****************************************************************
  // Register offsets and reset values
  // ****************************************************************
  localparam logic [1:0] RATE_MODE_OFFSET = 2'h1;
  localparam logic [1:0] REF_FILT_OFFSET = 2'h2;
  localparam logic [7:0] RATE_MODE_RESET = 8'h00;
  localparam logic [7:0] REF_FILT_RESET = 8'h00;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int RATE_MSB = 7;
  localparam int RATE_LSB = 5;
  localparam int MODE_MSB = 4;
  localparam int MODE_LSB = 3;
  localparam int CONT_BIT = 2;
  localparam int TEMP_BIT = 1;
  localparam int BURN_BIT = 0;
  localparam int VREF_MSB = 7;
  localparam int VREF_LSB = 6;
  localparam int FILT_MSB = 5;
  localparam int FILT_LSB = 4;
  localparam int SWITCH_BIT = 3;
  localparam int EXC_MSB = 2;
  localparam int EXC_LSB = 0;

  // ****************************************************************
  // Serial command byte layout
  // ****************************************************************
  localparam int CMD_WRITE_BIT = 7;
  localparam int CMD_ADDR_MSB = 1;
  localparam int CMD_ADDR_LSB = 0;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [1:0] CMD_INDEX = 2'h0;
  localparam logic [1:0] DATA_INDEX = 2'h1;

  // ****************************************************************
  // Encodings
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_DUTY,
    MODE_TURBO,
    MODE_UNUSED
  } op_mode_t;

  typedef enum logic [1:0] {
    REF_INTERNAL,
    REF_DEDICATED,
    REF_SHARED,
    REF_SUPPLY
  } ref_sel_t;

  localparam logic [1:0] FILT_NONE = 2'h0;
  localparam logic [2:0] RATE_SLOWEST = 3'h0;
  localparam logic [2:0] RATE_UNUSED = 3'h7;

  // Modulator clock per mode in kHz
  localparam logic [9:0] MOD_NORMAL_KHZ = 10'h100;
  localparam logic [9:0] MOD_TURBO_KHZ = 10'h200;

endpackage : adc_cfg_pkg

// ==== verilog/byte_link_if.sv ====
interface byte_link_if;
  logic [7:0] rx_byte;
  logic rx_valid;
  logic [1:0] rx_index;
  logic [7:0] tx_byte;
  logic tx_load;

  modport engine (
    output rx_byte,
    output rx_valid,
    output rx_index,
    input tx_byte,
    input tx_load
  );
  modport regs (
    input rx_byte,
    input rx_valid,
    input rx_index,
    output tx_byte,
    output tx_load
  );
endinterface : byte_link_if

// ==== verilog/serial_byte_engine.sv ====
module serial_byte_engine (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  byte_link_if.engine link
);

  // ****************************************************************
  // Edge detection on the serial clock
  // ****************************************************************
  logic sclk_prev_q;
  logic [2:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic [1:0] index_q;
  logic [7:0] rx_byte_q;
  logic rx_valid_q;
  logic [1:0] rx_index_q;
  logic miso_q;
  logic oe_q;
  wire sclk_fall = sclk_prev_q & ~sclk & ~cs_n;
  wire sclk_rise = ~sclk_prev_q & sclk & ~cs_n;
  wire [7:0] shift_next = {shift_q[6:0], mosi};

  // Sample on falling edges, mode 1 [R15]
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sclk_prev_q <= 1'b0;
      bit_cnt_q <= 3'h0;
      shift_q <= 8'h00;
      index_q <= 2'h0;
      rx_byte_q <= 8'h00;
      rx_valid_q <= 1'b0;
      rx_index_q <= 2'h0;
    end else if (ce) begin
      sclk_prev_q <= sclk;
      rx_valid_q <= 1'b0;
      if (cs_n) begin
        bit_cnt_q <= 3'h0;
        index_q <= 2'h0;
      end else if (sclk_fall) begin
        shift_q <= shift_next;
        bit_cnt_q <= bit_cnt_q + 3'h1;
        if (bit_cnt_q == adc_cfg_pkg::LAST_BIT) begin
          rx_byte_q <= shift_next;
          rx_valid_q <= 1'b1;
          rx_index_q <= index_q;
          // Saturate so long frames do not wrap onto the command slot
          if (index_q != 2'h3) begin
            index_q <= index_q + 2'h1;
          end
        end
      end
    end
  end

  // Launch on rising edges, MSB first; released while deselected [R15]
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tx_q <= 8'h00;
      miso_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (ce) begin
      oe_q <= ~cs_n;
      if (link.tx_load) begin
        tx_q <= link.tx_byte;
      end else if (sclk_rise) begin
        miso_q <= tx_q[7];
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end

  assign link.rx_byte = rx_byte_q;
  assign link.rx_valid = rx_valid_q;
  assign link.rx_index = rx_index_q;
  assign miso = miso_q;
  assign miso_oe = oe_q;

endmodule : serial_byte_engine

// ==== verilog/adc_config_registers.sv ====
// What this block does
// [R1] Rate field picks data rate per mode
// [R2] Mode field: normal, duty-cycle, turbo, unused
// [R3] Bit 2 selects continuous versus single-shot
// [R4] Temperature mode forces internal reference, ignores mux
// [R5] Bit 0 enables burn-out current sources
// [R6] Rates assume 4.096 MHz, scale otherwise
// [R7] Bits 7:6 select the conversion reference
// [R8] Line-rejection field sets filter coefficients
// [R9] Host uses rejection only at slowest rates
// [R10] Auto switch closes on launch, opens sleep
// [R11] Excitation field sets both sources together
// [R12] Excitation codes map to microamp levels
// [R13] Register at 02h resets to zero
// [R14] Register at 01h resets to zero
// [R15] Serial access is mode 1
// [R16] Reads return last written value
module adc_config_registers (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire logic launch_command,
  input wire logic sleep_command,
  output logic [2:0] rate_select,
  output adc_cfg_pkg::op_mode_t operating_mode,
  output logic continuous_conversion_enable,
  output logic temperature_sensor_enable,
  output logic burnout_source_enable,
  output adc_cfg_pkg::ref_sel_t reference_select,
  output logic [1:0] line_rejection,
  output logic low_side_switch_auto,
  output logic low_side_switch_closed,
  output logic [2:0] excitation_current_level,
  output logic [10:0] excitation_current_ua,
  output logic [13:0] output_rate_qsps,
  output logic [9:0] modulator_khz,
  output logic input_mux_ignored,
  output adc_cfg_pkg::ref_sel_t effective_reference,
  output logic line_rejection_misuse
);

  // ****************************************************************
  // Lookup functions
  // ****************************************************************

  // Nominal rate in quarter samples per second; zero for unused codes
  function automatic logic [13:0] rate_qsps(input logic [1:0] mode,
                                            input logic [2:0] code);
    logic [13:0] normal;
    logic [13:0] duty;
    normal = 14'h0000;
    duty = 14'h0000;
    case (code)
      3'h0: normal = 14'h0050;
      3'h1: normal = 14'h00b4;
      3'h2: normal = 14'h0168;
      3'h3: normal = 14'h02bc;
      3'h4: normal = 14'h0528;
      3'h5: normal = 14'h0960;
      3'h6: normal = 14'h0fa0;
      default: normal = 14'h0000;
    endcase
    // Duty-cycle rates get their own table: 44 SPS is not 175 / 4
    case (code)
      3'h0: duty = 14'h0014;
      3'h1: duty = 14'h002d;
      3'h2: duty = 14'h005a;
      3'h3: duty = 14'h00b0;
      3'h4: duty = 14'h014a;
      3'h5: duty = 14'h0258;
      3'h6: duty = 14'h03e8;
      default: duty = 14'h0000;
    endcase
    case (mode)
      2'h0: rate_qsps = normal;
      2'h1: rate_qsps = duty;
      2'h2: rate_qsps = {normal[12:0], 1'b0};
      default: rate_qsps = 14'h0000;
    endcase
  endfunction : rate_qsps

  // Excitation magnitude in microamps; unused code reads as off
  function automatic logic [10:0] exc_ua(input logic [2:0] code);
    case (code)
      3'h2: exc_ua = 11'h032;
      3'h3: exc_ua = 11'h064;
      3'h4: exc_ua = 11'h0fa;
      3'h5: exc_ua = 11'h1f4;
      3'h6: exc_ua = 11'h3e8;
      3'h7: exc_ua = 11'h5dc;
      default: exc_ua = 11'h000;
    endcase
  endfunction : exc_ua

  // ****************************************************************
  // Serial byte engine
  // ****************************************************************
  byte_link_if link ();

  serial_byte_engine u_engine (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .sclk(sclk),
    .cs_n(cs_n),
    .mosi(mosi),
    .miso(miso),
    .miso_oe(miso_oe),
    .link(link)
  );

  // ****************************************************************
  // Command decode and register storage
  // ****************************************************************
  logic [7:0] rate_mode_q;
  logic [7:0] ref_filt_q;
  logic write_pending_q;
  logic [1:0] addr_q;
  wire cmd_seen = link.rx_valid & (link.rx_index == adc_cfg_pkg::CMD_INDEX);
  wire data_seen = link.rx_valid & write_pending_q &
                   (link.rx_index == adc_cfg_pkg::DATA_INDEX);
  wire [1:0] cmd_addr = link.rx_byte[adc_cfg_pkg::CMD_ADDR_MSB:
                                     adc_cfg_pkg::CMD_ADDR_LSB];
  wire wr_rate_mode = data_seen & (addr_q == adc_cfg_pkg::RATE_MODE_OFFSET);
  wire wr_ref_filt = data_seen & (addr_q == adc_cfg_pkg::REF_FILT_OFFSET);

  // Readback mux; addresses held elsewhere answer zero [R16]
  assign link.tx_load = cmd_seen;
  assign link.tx_byte =
    (cmd_addr == adc_cfg_pkg::RATE_MODE_OFFSET) ? rate_mode_q :
    (cmd_addr == adc_cfg_pkg::REF_FILT_OFFSET) ? ref_filt_q : 8'h00;

  // Command byte with bit 7 set arms a write for the byte that follows it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      write_pending_q <= 1'b0;
      addr_q <= 2'h0;
    end else if (ce) begin
      if (cmd_seen) begin
        write_pending_q <= link.rx_byte[adc_cfg_pkg::CMD_WRITE_BIT];
        addr_q <= cmd_addr;
      end else if (data_seen) begin
        write_pending_q <= 1'b0;
      end
    end
  end

  // Both registers clear on reset and hold written bytes [R13] [R14] [R16]
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rate_mode_q <= adc_cfg_pkg::RATE_MODE_RESET;
      ref_filt_q <= adc_cfg_pkg::REF_FILT_RESET;
    end else if (ce) begin
      if (wr_rate_mode) begin
        rate_mode_q <= link.rx_byte;
      end
      if (wr_ref_filt) begin
        ref_filt_q <= link.rx_byte;
      end
    end
  end

  // ****************************************************************
  // Field decode
  // ****************************************************************
  wire [2:0] rate_f = rate_mode_q[adc_cfg_pkg::RATE_MSB:adc_cfg_pkg::RATE_LSB];
  wire [1:0] mode_f = rate_mode_q[adc_cfg_pkg::MODE_MSB:adc_cfg_pkg::MODE_LSB];
  wire temp_f = rate_mode_q[adc_cfg_pkg::TEMP_BIT];
  wire [1:0] vref_f = ref_filt_q[adc_cfg_pkg::VREF_MSB:adc_cfg_pkg::VREF_LSB];
  wire [1:0] filt_f = ref_filt_q[adc_cfg_pkg::FILT_MSB:adc_cfg_pkg::FILT_LSB];
  wire switch_f = ref_filt_q[adc_cfg_pkg::SWITCH_BIT];
  wire [2:0] exc_f = ref_filt_q[adc_cfg_pkg::EXC_MSB:adc_cfg_pkg::EXC_LSB];
  // Only the slowest normal or duty-cycle rate may carry rejection
  wire slow_rate_ok = (rate_f == adc_cfg_pkg::RATE_SLOWEST) &&
                      (mode_f == 2'h0 || mode_f == 2'h1);
  wire [9:0] mod_khz_d =
    (mode_f == 2'h2) ? adc_cfg_pkg::MOD_TURBO_KHZ :
    (mode_f == 2'h3) ? 10'h000 : adc_cfg_pkg::MOD_NORMAL_KHZ;

  // Registered field outputs, one cycle behind the storage
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rate_select <= 3'h0;
      operating_mode <= adc_cfg_pkg::MODE_NORMAL;
      continuous_conversion_enable <= 1'b0;
      temperature_sensor_enable <= 1'b0;
      burnout_source_enable <= 1'b0;
      reference_select <= adc_cfg_pkg::REF_INTERNAL;
      line_rejection <= adc_cfg_pkg::FILT_NONE;
      low_side_switch_auto <= 1'b0;
      excitation_current_level <= 3'h0;
      excitation_current_ua <= 11'h000;
      output_rate_qsps <= 14'h0000;
      modulator_khz <= 10'h000;
      input_mux_ignored <= 1'b0;
      effective_reference <= adc_cfg_pkg::REF_INTERNAL;
      line_rejection_misuse <= 1'b0;
    end else if (ce) begin
      rate_select <= rate_f; // [R1]
      operating_mode <= adc_cfg_pkg::op_mode_t'(mode_f); // [R2]
      continuous_conversion_enable <= rate_mode_q[adc_cfg_pkg::CONT_BIT]; // [R3]
      temperature_sensor_enable <= temp_f; // [R4]
      burnout_source_enable <= rate_mode_q[adc_cfg_pkg::BURN_BIT]; // [R5]
      reference_select <= adc_cfg_pkg::ref_sel_t'(vref_f); // [R7]
      line_rejection <= filt_f; // [R8]
      low_side_switch_auto <= switch_f; // [R10]
      excitation_current_level <= exc_f; // [R11]
      excitation_current_ua <= exc_ua(exc_f); // [R12]
      // Nominal at a 4.096 MHz clock; scale by the real clock [R1] [R6]
      output_rate_qsps <= rate_qsps(mode_f, rate_f);
      modulator_khz <= mod_khz_d; // [R2]
      input_mux_ignored <= temp_f; // [R4]
      effective_reference <= temp_f ? adc_cfg_pkg::REF_INTERNAL :
                             adc_cfg_pkg::ref_sel_t'(vref_f); // [R4]
      // Flag only; the field is still stored as written [R9]
      line_rejection_misuse <= (filt_f != adc_cfg_pkg::FILT_NONE) &&
                               !slow_rate_ok;
    end
  end

  // ****************************************************************
  // Low-side switch
  // ****************************************************************

  // Sleep wins over a coincident launch so the switch never sticks closed
  always_ff @(posedge clk) begin
    if (!nrst) begin
      low_side_switch_closed <= 1'b0;
    end else if (ce) begin
      if (!switch_f || sleep_command) begin
        low_side_switch_closed <= 1'b0; // [R10]
      end else if (launch_command) begin
        low_side_switch_closed <= 1'b1; // [R10]
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence write_rate_s;
    ce && wr_rate_mode;
  endsequence
  sequence write_ref_s;
    ce && wr_ref_filt;
  endsequence

  rate_write_a: assert property (write_rate_s |=> // [R14] [R16]
    rate_mode_q == $past(link.rx_byte))
    else $error("rate register missed a write");
  ref_write_a: assert property (write_ref_s |=> // [R13] [R16]
    ref_filt_q == $past(link.rx_byte))
    else $error("reference register missed a write");
  regs_hold_a: assert property (!wr_rate_mode && !wr_ref_filt |=> // [R16]
    $stable(rate_mode_q) && $stable(ref_filt_q))
    else $error("register changed without a write");
  reset_clear_a: assert property (@(posedge clk) disable iff (1'b0)
    !nrst |=> rate_mode_q == 8'h00 && ref_filt_q == 8'h00 // [R13] [R14]
    && output_rate_qsps == 14'h0000)
    else $error("registers not cleared by reset");
  readback_a: assert property (ce && cmd_seen && // [R16]
    cmd_addr == adc_cfg_pkg::REF_FILT_OFFSET |-> link.tx_byte == ref_filt_q)
    else $error("readback byte differs from register");
  rate_table_a: assert property (ce && rate_f == 3'h6 && // [R1]
    mode_f == 2'h2 |=> output_rate_qsps == 14'h1f40)
    else $error("turbo top rate not 2000 SPS");
  mode_clock_a: assert property (ce && mode_f == 2'h1 |=> // [R2]
    modulator_khz == 10'h100 && output_rate_qsps <= 14'h03e8)
    else $error("duty-cycle rate wrong");
  duty_rate_a: assert property (ce && mode_f == 2'h1 && // [R1]
    rate_f == 3'h3 |=> output_rate_qsps == 14'h00b0)
    else $error("duty-cycle 44 SPS rate wrong");
  temp_ref_a: assert property (ce && temp_f |=> // [R4]
    effective_reference == adc_cfg_pkg::REF_INTERNAL && input_mux_ignored)
    else $error("temperature mode did not force reference");
  exc_map_a: assert property (ce && exc_f == 3'h1 |=> // [R12]
    excitation_current_ua == 11'h000)
    else $error("unused excitation code not off");
  switch_open_a: assert property (ce && (!switch_f || sleep_command) |=> // [R10]
    !low_side_switch_closed)
    else $error("low-side switch left closed");
  switch_close_a: assert property (ce && switch_f && !sleep_command && // [R10]
    launch_command |=> low_side_switch_closed [*1] ##1
    (low_side_switch_closed || !switch_f || $past(sleep_command)
     || !$past(ce)))
    else $error("low-side switch failed to close");
  misuse_flag_a: assert property (ce && rate_f != 3'h0 && // [R9]
    filt_f != 2'h0 |=> line_rejection_misuse)
    else $error("rejection misuse not flagged");
  read_arm_a: assert property (ce && cmd_seen && // [R16]
    !link.rx_byte[adc_cfg_pkg::CMD_WRITE_BIT] |=> !write_pending_q)
    else $error("read command armed a write");
  field_copy_a: assert property (ce |=> // [R3] [R5]
    continuous_conversion_enable == $past(rate_mode_q[adc_cfg_pkg::CONT_BIT])
    && burnout_source_enable == $past(rate_mode_q[adc_cfg_pkg::BURN_BIT]))
    else $error("conversion or burn-out bit not copied");

endmodule : adc_config_registers

// ==== testbench/spi_host_model.sv ====
module spi_host_model (
  input wire logic clk,
  input wire logic miso,
  output logic sclk,
  output logic cs_n,
  output logic mosi
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Serial host: mode 1, clock idles low
  // ****************************************************************
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b1;
  end

  // One whole frame, command then data, MSB first; caller enters just
  // after a falling clk edge. Phases of 4 clk keep above the 2 clk floor.
  task automatic frame(input logic [7:0] cmd, input logic [7:0] data,
                       output logic [7:0] rdata);
    logic [15:0] tx;
    tx = {cmd, data};
    rdata = 8'h00;
    cs_n = 1'b0;
    repeat (4) @(negedge clk);
    for (int b = 0; b < 16; b++) begin
      mosi = tx[15 - b]; // Launched with the rising edge
      sclk = 1'b1;
      repeat (4) @(negedge clk);
      if (b >= 8) begin
        rdata = {rdata[6:0], miso}; // Taken before the fall
      end
      sclk = 1'b0;
      repeat (4) @(negedge clk);
    end
    cs_n = 1'b1;
    // Released line shows the inverse so a stale bit cannot pass
    mosi = ~mosi;
    repeat (4) @(negedge clk);
  endtask : frame
endmodule : spi_host_model

// ==== testbench/test_adc_config_registers.sv ====
module test_adc_config_registers;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, nrst, ce, sclk, cs_n, mosi, miso, miso_oe;
  logic launch_command, sleep_command, cont, temp, burn, sw_auto, sw_closed;
  logic mux_ignored, misuse;
  logic [2:0] rate_select, exc_level;
  logic [1:0] line_rejection;
  logic [10:0] exc_ua;
  logic [13:0] qsps;
  logic [9:0] mod_khz;
  adc_cfg_pkg::op_mode_t operating_mode;
  adc_cfg_pkg::ref_sel_t ref_sel, eff_ref;
  int n_errors = 0;
  int checks_done = 0;

  // ****************************************************************
  // Clock, instances
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  spi_host_model i_host (.clk(clk), .miso(miso), .sclk(sclk),
    .cs_n(cs_n), .mosi(mosi));

  adc_config_registers i_dut (.clk(clk), .nrst(nrst), .ce(ce),
    .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe), .launch_command(launch_command),
    .sleep_command(sleep_command), .rate_select(rate_select),
    .operating_mode(operating_mode),
    .continuous_conversion_enable(cont),
    .temperature_sensor_enable(temp), .burnout_source_enable(burn),
    .reference_select(ref_sel), .line_rejection(line_rejection),
    .low_side_switch_auto(sw_auto), .low_side_switch_closed(sw_closed),
    .excitation_current_level(exc_level),
    .excitation_current_ua(exc_ua), .output_rate_qsps(qsps),
    .modulator_khz(mod_khz), .input_mux_ignored(mux_ignored),
    .effective_reference(eff_ref), .line_rejection_misuse(misuse));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [1:0] addr, input logic [7:0] val);
    logic [7:0] unused;
    i_host.frame({1'b1, 5'h00, addr}, val, unused);
  endtask : wr

  // Data byte of a read is junk on purpose: it must be ignored
  task automatic rd(input logic [1:0] addr, input logic [7:0] exp);
    logic [7:0] got;
    i_host.frame({1'b0, 5'h15, addr}, 8'h5a, got);
    check("readback", {8'h00, got}, {8'h00, exp});
  endtask : rd

  // Quarter-SPS rate per mode and code, worked out from the rate table
  function automatic logic [13:0] exp_rate(logic [2:0] r, logic [1:0] m);
    logic [13:0] n;
    case (r)
      3'h0: n = (m == 2'h1) ? 14'h014 : 14'h050;
      3'h1: n = (m == 2'h1) ? 14'h02d : 14'h0b4;
      3'h2: n = (m == 2'h1) ? 14'h05a : 14'h168;
      3'h3: n = (m == 2'h1) ? 14'h0b0 : 14'h2bc;
      3'h4: n = (m == 2'h1) ? 14'h14a : 14'h528;
      3'h5: n = (m == 2'h1) ? 14'h258 : 14'h960;
      3'h6: n = (m == 2'h1) ? 14'h3e8 : 14'hfa0;
      default: n = 14'h000;
    endcase
    if (m == 2'h2) n = n << 1;
    if (m == 2'h3) n = 14'h000;
    return n;
  endfunction : exp_rate

  task automatic pulse(input logic l, input logic s, input logic exp);
    launch_command = l;
    sleep_command = s;
    @(negedge clk);
    launch_command = 1'b0;
    sleep_command = 1'b0;
    repeat (2) @(negedge clk);
    check("switch_closed", {15'h0, sw_closed}, {15'h0, exp});
  endtask : pulse

  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    finish_test();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [7:0] v;
    nrst = 1'b0;
    ce = 1'b1;
    launch_command = 1'b0;
    sleep_command = 1'b0;
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    rd(adc_cfg_pkg::RATE_MODE_OFFSET, 8'h00);
    rd(adc_cfg_pkg::REF_FILT_OFFSET, 8'h00);
    check("fields", {exc_level, ref_sel, line_rejection, sw_auto},
          16'h0);
    // Every rate code in every mode, with the low bits walking
    for (int i = 0; i < 32; i++) begin
      v = {i[2:0], i[4:3], i[2:0]};
      wr(adc_cfg_pkg::RATE_MODE_OFFSET, v);
      check("rate", {13'h0, rate_select}, {13'h0, v[7:5]});
      check("qsps", {2'h0, qsps}, {2'h0, exp_rate(v[7:5], v[4:3])});
      check("mode", {14'h0, operating_mode}, {14'h0, v[4:3]});
      check("mod_khz", {6'h0, mod_khz},
            (v[4:3] == 2'h3) ? 16'h0 : (v[4] ? 16'h200 : 16'h100));
      check("cont", {15'h0, cont}, {15'h0, v[2]});
      check("temp", {15'h0, mux_ignored}, {15'h0, v[1]});
      check("temp_en", {15'h0, temp}, {15'h0, v[1]});
      check("burn", {15'h0, burn}, {15'h0, v[0]});
      rd(adc_cfg_pkg::RATE_MODE_OFFSET, v);
    end
    // Every reference and excitation code
    for (int i = 0; i < 32; i++) begin
      v = {i[4:3], 2'h0, i[3], i[2:0]};
      wr(adc_cfg_pkg::REF_FILT_OFFSET, v);
      check("ref", {14'h0, ref_sel}, {14'h0, v[7:6]});
      check("exc", {13'h0, exc_level}, {13'h0, v[2:0]});
      check("sw_auto", {15'h0, sw_auto}, {15'h0, v[3]});
      case (v[2:0])
        3'h2: check("ua", {5'h0, exc_ua}, 16'h0032);
        3'h3: check("ua", {5'h0, exc_ua}, 16'h0064);
        3'h4: check("ua", {5'h0, exc_ua}, 16'h00fa);
        3'h5: check("ua", {5'h0, exc_ua}, 16'h01f4);
        3'h6: check("ua", {5'h0, exc_ua}, 16'h03e8);
        3'h7: check("ua", {5'h0, exc_ua}, 16'h05dc);
        default: check("ua", {5'h0, exc_ua}, 16'h0000);
      endcase
      rd(adc_cfg_pkg::REF_FILT_OFFSET, v);
    end
    // Temperature mode forces the internal reference
    wr(adc_cfg_pkg::RATE_MODE_OFFSET, 8'h02);
    check("eff_ref", {14'h0, eff_ref}, 16'h0);
    wr(adc_cfg_pkg::RATE_MODE_OFFSET, 8'h00);
    check("eff_ref", {14'h0, eff_ref}, 16'h3);
    // Rejection codes at the slowest normal rate, then at a faster one
    for (int f = 1; f < 4; f++) begin
      wr(adc_cfg_pkg::REF_FILT_OFFSET, {2'h0, f[1:0], 4'h0});
      check("rejection", {14'h0, line_rejection}, {14'h0, f[1:0]});
      check("misuse", {15'h0, misuse}, 16'h0);
    end
    wr(adc_cfg_pkg::RATE_MODE_OFFSET, 8'h08);
    check("misuse", {15'h0, misuse}, 16'h0);
    wr(adc_cfg_pkg::RATE_MODE_OFFSET, 8'h20);
    check("misuse", {15'h0, misuse}, 16'h1);
    // Low-side switch
    pulse(1'b1, 1'b0, 1'b0);
    wr(adc_cfg_pkg::REF_FILT_OFFSET, 8'h08);
    pulse(1'b1, 1'b0, 1'b1);
    pulse(1'b0, 1'b1, 1'b0);
    pulse(1'b1, 1'b1, 1'b0);
    pulse(1'b1, 1'b0, 1'b1);
    wr(adc_cfg_pkg::REF_FILT_OFFSET, 8'h00);
    check("switch_open", {15'h0, sw_closed}, 16'h0);
    // Unmapped places hold nothing and disturb nothing
    wr(2'h0, 8'hff);
    wr(2'h3, 8'hff);
    rd(2'h0, 8'h00);
    rd(2'h3, 8'h00);
    rd(adc_cfg_pkg::RATE_MODE_OFFSET, 8'h20);
    // Output enable follows the select, one clock late
    fork
      wr(adc_cfg_pkg::REF_FILT_OFFSET, 8'hc7);
      begin
        repeat (3) @(negedge clk);
        check("miso_oe", {15'h0, miso_oe}, 16'h1);
      end
    join
    check("miso_oe", {15'h0, miso_oe}, 16'h0);
    // Clock enable low freezes everything, so this frame is lost
    ce = 1'b0;
    wr(adc_cfg_pkg::REF_FILT_OFFSET, 8'h3c);
    ce = 1'b1;
    rd(adc_cfg_pkg::REF_FILT_OFFSET, 8'hc7);
    // Mid-run reset returns both registers to zero
    @(negedge clk);
    nrst = 1'b0;
    @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    rd(adc_cfg_pkg::RATE_MODE_OFFSET, 8'h00);
    rd(adc_cfg_pkg::REF_FILT_OFFSET, 8'h00);
    check("rate_rst", {13'h0, rate_select}, 16'h0);
    finish_test();
  end
endmodule : test_adc_config_registers
